// ==== core/acrs_sequencer.sv ====
`timescale 1ns/1ps

module acrs_sequencer (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic converter_enable_bit,
    input wire logic auto_trigger_enable_bit,
    input wire logic free_running_select,
    input wire logic [2:0] clock_prescale_select,
    input wire logic [1:0] track_hold_time_setting,
    input wire logic [4:0] startup_time_setting,
    input wire logic start_write,
    input wire logic done_flag_clear,
    input wire logic done_irq_enable,
    input wire logic sleep_halted,
    input wire logic channel_select_high_write,
    input wire logic channel_select_high,
    input wire logic channel_select_low_write,
    input wire logic [4:0] channel_select_low,
    input wire logic reference_select_write,
    input wire logic [1:0] reference_select_bits,
    input wire logic trigger_pin,
    input wire logic analog_supply_ok_pin,
    input wire logic reference_ready_pin,
    input wire logic over_range,
    input wire logic [9:0] core_result,
    output logic conversion_start_bit_q,
    output logic conversion_done_flag_q,
    output logic [9:0] result_q,
    output logic [5:0] active_channel_q,
    output logic [3:0] reference_source_q,
    output logic reference_stable_flag_q,
    output logic sample_hold_q,
    output logic converting_q,
    output logic tracking_q,
    output logic settling_q
);

    typedef enum logic [2:0] {
        ACRS_OFF,
        ACRS_STARTUP,
        ACRS_IDLE,
        ACRS_CHSYNC,
        ACRS_SETTLE,
        ACRS_DELAY,
        ACRS_CONVERT,
        ACRS_TRACK
    } acrs_state_t;

    acrs_state_t state_q;
    acrs_state_t state_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic trig_prev_q;
    logic halt_prev_q;
    logic tick;
    logic diff;
    logic chan_high_tmp_q;
    logic [5:0] chan_buffer_q;
    logic [1:0] ref_tmp_q;
    logic [1:0] active_ref_q;
    logic chan_lock_q;
    logic ref_lock_q;
    logic chg_pend_q;
    logic start_pend_q;
    logic trig_edge;
    logic sleep_start;
    logic new_request;
    logic free_run;
    logic go_conv;
    logic sample_evt;
    logic done_evt;

    // Pins from the analog side and the trigger are foreign; two flops each
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {reference_ready_pin, analog_supply_ok_pin, trigger_pin};
            sync2_q <= sync1_q;
        end
    end

    // Edge history for the trigger and the sleep halt
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_prev_q <= 1'b0;
            halt_prev_q <= 1'b0;
        end
        else
        begin
            trig_prev_q <= sync2_q[0];
            halt_prev_q <= sleep_halted;
        end
    end

    assign diff = acrs_pkg::acrs_is_diff(active_channel_q);
    assign free_run = auto_trigger_enable_bit & free_running_select & conversion_start_bit_q;

    // Edges during a conversion are dropped rather than queued
    assign trig_edge = auto_trigger_enable_bit & ~free_running_select & sync2_q[0]
                       & ~trig_prev_q & ~conversion_start_bit_q;
    // Noise canceller start once the CPU halts
    assign sleep_start = sleep_halted & ~halt_prev_q & converter_enable_bit
                         & ~conversion_start_bit_q & ~auto_trigger_enable_bit
                         & done_irq_enable;
    assign new_request = converter_enable_bit & (start_write | trig_edge | sleep_start);

    acrs_prescaler u_prescaler (
        .clock(clock),
        .reset_n(reset_n),
        .run(converter_enable_bit),
        .restart(trig_edge),
        .clock_prescale_select(clock_prescale_select),
        .tick_q(tick)
    );

    // Next-state logic; phase counters only count down on converter ticks
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        go_conv = 1'b0;
        sample_evt = 1'b0;
        done_evt = 1'b0;
        if (!converter_enable_bit)
        begin
            state_d = ACRS_OFF;
            cnt_d = 8'h00;
        end
        else
        begin
            case (state_q)
                ACRS_OFF:
                begin
                    if (sync2_q[1])
                    begin
                        state_d = ACRS_STARTUP;
                        cnt_d = acrs_pkg::acrs_startup_ticks(diff, startup_time_setting,
                                                             track_hold_time_setting) - 8'h01;
                    end
                end
                ACRS_STARTUP:
                begin
                    if (tick)
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            state_d = ACRS_IDLE;
                        end
                        else
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                end
                ACRS_IDLE:
                begin
                    if (chg_pend_q)
                    begin
                        state_d = ACRS_CHSYNC;
                        cnt_d = 8'(acrs_pkg::CHAN_SYNC_TICKS - 1);
                    end
                    else if (start_pend_q && tick)
                    begin
                        go_conv = 1'b1;
                    end
                end
                ACRS_TRACK:
                begin
                    if (chg_pend_q)
                    begin
                        state_d = ACRS_CHSYNC;
                        cnt_d = 8'(acrs_pkg::CHAN_SYNC_TICKS - 1);
                    end
                    else if (tick)
                    begin
                        if (cnt_q != 8'h00)
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                        else if (start_pend_q || free_run)
                        begin
                            go_conv = 1'b1;
                        end
                        else
                        begin
                            state_d = ACRS_IDLE;
                        end
                    end
                end
                ACRS_CHSYNC:
                begin
                    if (tick)
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            state_d = ACRS_SETTLE;
                            cnt_d = {6'h00, track_hold_time_setting} + 8'h01;
                        end
                        else
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                end
                ACRS_SETTLE:
                begin
                    if (tick)
                    begin
                        if (cnt_q != 8'h00)
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                        else if (start_pend_q || free_run)
                        begin
                            go_conv = 1'b1;
                        end
                        else
                        begin
                            state_d = ACRS_IDLE;
                        end
                    end
                end
                ACRS_DELAY:
                begin
                    if (tick)
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            state_d = ACRS_CONVERT;
                            cnt_d = 8'(acrs_pkg::CONV_TICKS - 1);
                            sample_evt = 1'b1;
                        end
                        else
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                end
                ACRS_CONVERT:
                begin
                    if (tick)
                    begin
                        if (cnt_q == 8'h00)
                        begin
                            done_evt = 1'b1;
                            state_d = ACRS_TRACK;
                            cnt_d = acrs_pkg::acrs_track_ticks(diff, track_hold_time_setting,
                                                               clock_prescale_select)
                                    - 8'h01;
                        end
                        else
                        begin
                            cnt_d = cnt_q - 8'h01;
                        end
                    end
                end
                default:
                begin
                    state_d = ACRS_OFF;
                end
            endcase
            // Requested differential starts wait two ticks; free-running repeats do not
            if (go_conv && diff && start_pend_q)
            begin
                state_d = ACRS_DELAY;
                cnt_d = 8'(acrs_pkg::DIFF_START_TICKS - 1);
            end
            else if (go_conv)
            begin
                state_d = ACRS_CONVERT;
                cnt_d = 8'(acrs_pkg::CONV_TICKS - 1);
                sample_evt = 1'b1;
            end
        end
    end

    // Sequencer state and phase counter
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ACRS_OFF;
            cnt_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Phase outputs, registered from the next state so they line up with it
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_hold_q <= 1'b0;
            converting_q <= 1'b0;
            tracking_q <= 1'b0;
            settling_q <= 1'b0;
        end
        else
        begin
            sample_hold_q <= sample_evt;
            converting_q <= (state_d == ACRS_CONVERT);
            tracking_q <= (state_d == ACRS_TRACK);
            settling_q <= (state_d == ACRS_CHSYNC) || (state_d == ACRS_SETTLE);
        end
    end

    // Start bit and the held request; a new request beats completion
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conversion_start_bit_q <= 1'b0;
            start_pend_q <= 1'b0;
        end
        else if (!converter_enable_bit)
        begin
            conversion_start_bit_q <= 1'b0;
            start_pend_q <= 1'b0;
        end
        else
        begin
            if (new_request)
            begin
                conversion_start_bit_q <= 1'b1;
            end
            else if (done_evt && !free_run)
            begin
                conversion_start_bit_q <= 1'b0;
            end
            if (new_request)
            begin
                start_pend_q <= 1'b1;
            end
            else if (go_conv)
            begin
                start_pend_q <= 1'b0;
            end
        end
    end

    // Done flag and result; a completion in the clearing cycle is kept
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conversion_done_flag_q <= 1'b0;
            result_q <= 10'h000;
        end
        else if (done_evt)
        begin
            conversion_done_flag_q <= 1'b1;
            result_q <= (over_range && !diff) ? acrs_pkg::FULL_SCALE : core_result;
        end
        else if (done_flag_clear)
        begin
            conversion_done_flag_q <= 1'b0;
        end
    end

    // Temporary selection registers; only the low-field write loads the buffer
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_high_tmp_q <= 1'b0;
            chan_buffer_q <= acrs_pkg::CHANNEL_RESET;
            ref_tmp_q <= acrs_pkg::REFERENCE_RESET;
        end
        else
        begin
            if (channel_select_high_write)
            begin
                chan_high_tmp_q <= channel_select_high;
            end
            if (channel_select_low_write)
            begin
                chan_buffer_q <= {chan_high_tmp_q, channel_select_low};
            end
            if (reference_select_write)
            begin
                ref_tmp_q <= reference_select_bits;
            end
        end
    end

    // Channel lock: set by a start request or a sample start, released by completion
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_lock_q <= 1'b0;
        end
        else if (!converter_enable_bit || done_evt)
        begin
            chan_lock_q <= 1'b0;
        end
        else if (new_request || go_conv)
        begin
            chan_lock_q <= 1'b1;
        end
    end

    // Active channel follows the buffer while unlocked; a change while
    // running asks for sync and settling before the next sample
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_channel_q <= acrs_pkg::CHANNEL_RESET;
            chg_pend_q <= 1'b0;
        end
        else if (!chan_lock_q && !new_request && !go_conv && chan_buffer_q != active_channel_q)
        begin
            active_channel_q <= chan_buffer_q;
            chg_pend_q <= converter_enable_bit
                          && (state_q == ACRS_IDLE || state_q == ACRS_TRACK
                              || state_q == ACRS_CHSYNC
                              || state_q == ACRS_SETTLE);
        end
        else if (!converter_enable_bit || state_q == ACRS_CHSYNC)
        begin
            chg_pend_q <= 1'b0;
        end
    end

    // Reference freezes at the first start and thaws only on disable
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_lock_q <= 1'b0;
            active_ref_q <= acrs_pkg::REFERENCE_RESET;
        end
        else if (!converter_enable_bit)
        begin
            ref_lock_q <= 1'b0;
            active_ref_q <= ref_tmp_q;
        end
        else if (new_request)
        begin
            ref_lock_q <= 1'b1;
        end
        else if (!ref_lock_q)
        begin
            active_ref_q <= ref_tmp_q;
        end
    end

    // One-hot reference switch control and stability status
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reference_source_q <= 4'h0;
            reference_stable_flag_q <= 1'b0;
        end
        else
        begin
            case (active_ref_q)
                acrs_pkg::REF_SUPPLY: reference_source_q <= 4'h1;
                acrs_pkg::REF_INT_1V5: reference_source_q <= 4'h2;
                acrs_pkg::REF_INT_1V6: reference_source_q <= 4'h4;
                acrs_pkg::REF_EXT_PIN: reference_source_q <= 4'h8;
                default: reference_source_q <= 4'h0;
            endcase
            reference_stable_flag_q <= sync2_q[2] && (active_ref_q == acrs_pkg::REF_INT_1V5
                                       || active_ref_q == acrs_pkg::REF_INT_1V6);
        end
    end

endmodule : acrs_sequencer

// ==== common/acrs_pkg.sv ====
package acrs_pkg;

    // Converter timing, counted in converter clock ticks unless named otherwise
    localparam int CONV_TICKS = 11;
    localparam int DIFF_START_TICKS = 2;
    localparam int CHAN_SYNC_TICKS = 2;
    localparam int STARTUP_MULT = 4;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int TRACK_MIN_NS = 500;
    localparam int TRACK_MIN_CLK = (TRACK_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Result code for a single-ended input above the reference
    localparam logic [9:0] FULL_SCALE = 10'h3ff;

    // Reference select encodings
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_INT_1V5 = 2'h1;
    localparam logic [1:0] REF_INT_1V6 = 2'h2;
    localparam logic [1:0] REF_EXT_PIN = 2'h3;

    // Reset values of the selection registers
    localparam logic [5:0] CHANNEL_RESET = 6'h00;
    localparam logic [1:0] REFERENCE_RESET = 2'h0;

    // Prescaler divides by two to the power of this exponent
    function automatic logic [2:0] acrs_div_exp(input logic [2:0] ps);
        return (ps == 3'h0) ? 3'h1 : ps;
    endfunction : acrs_div_exp

    // Differential codes sit on the high select bit or low codes 8 and up
    function automatic logic acrs_is_diff(input logic [5:0] ch);
        return ch[5] | (ch[4:3] != 2'b00);
    endfunction : acrs_is_diff

    // Tracking phase length, with the 500 ns floor for single-ended inputs
    function automatic logic [7:0] acrs_track_ticks(input logic diff, input logic [1:0] tht,
                                                    input logic [2:0] ps);
        logic [7:0] base;
        logic [7:0] floor_t;
        logic [2:0] e;
        e = acrs_div_exp(ps);
        base = diff ? ({5'h00, tht, 1'b0} + 8'h03) : ({6'h00, tht} + 8'h01);
        floor_t = 8'((TRACK_MIN_CLK + (32'd1 << e) - 1) >> e);
        return (!diff && floor_t > base) ? floor_t : base;
    endfunction : acrs_track_ticks

    // Start-up length, plus amplifier initialisation for differential inputs
    function automatic logic [7:0] acrs_startup_ticks(input logic diff, input logic [4:0] sut,
                                                      input logic [1:0] tht);
        logic [7:0] amp;
        amp = diff ? {5'h00, tht, 1'b0} + 8'h04 : 8'h00;
        return 8'(STARTUP_MULT * ({3'h0, sut} + 8'h01)) + amp;
    endfunction : acrs_startup_ticks

endpackage : acrs_pkg

// ==== core/acrs_prescaler.sv ====
`timescale 1ns/1ps

// Converter clock tick generator; held cleared while the converter is off
module acrs_prescaler (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] clock_prescale_select,
    output logic tick_q
);

    logic [6:0] count_q;
    logic [6:0] last;

    // Terminal count for the selected division
    assign last = 7'((8'h01 << acrs_pkg::acrs_div_exp(clock_prescale_select)) - 8'h01);

    // Counter restarts on a trigger edge so sampling lines up with it
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (!run || restart)
        begin
            count_q <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (count_q >= last)
        begin
            count_q <= 7'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

endmodule : acrs_prescaler

// ==== testbench/acrs_analog_model.sv ====
`timescale 1ns/1ps
// Analog side: supply rail, reference buffer and converter core
module acrs_analog_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [5:0] channel,
    input wire logic hot,
    output logic supply_ok,
    output logic ref_ready,
    output logic over_range,
    output logic [9:0] core_result
);
    logic [3:0] up_q;
    // Rail and reference come up late, so early requests must be held
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            up_q <= 4'h0;
        else if (up_q != 4'hf)
            up_q <= up_q + 4'h1;
    end
    assign supply_ok = (up_q == 4'hf);
    assign ref_ready = supply_ok;
    // Code follows the channel, so a stale selection shows in the result
    assign over_range = hot;
    assign core_result = {4'h0, channel} + 10'h100;
endmodule : acrs_analog_model

// ==== testbench/acrs_seq_checker.sv ====
`timescale 1ns/1ps
// Timing relations between the sequencer outputs
module acrs_seq_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic converter_enable_bit,
    input wire logic free_running_select,
    input wire logic over_range,
    input wire logic [2:0] clock_prescale_select,
    input wire logic conversion_start_bit_q,
    input wire logic conversion_done_flag_q,
    input wire logic [9:0] result_q,
    input wire logic [5:0] active_channel_q,
    input wire logic [3:0] reference_source_q,
    input wire logic reference_stable_flag_q,
    input wire logic sample_hold_q,
    input wire logic converting_q,
    input wire logic tracking_q,
    input wire logic settling_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_sh_pulse: assert property (sample_hold_q |=> !sample_hold_q)
        else $error("sh width");
    chk_sh_convert: assert property ($rose(sample_hold_q) |-> converting_q)
        else $error("sh");
    chk_conv_length: assert property ($rose(converting_q) && clock_prescale_select == 3'h1
        |-> ##19 converting_q ##[1:4] !converting_q) else $error("conv length");
    chk_done_start: assert property ($rose(conversion_done_flag_q) && !free_running_select
        |-> !conversion_start_bit_q) else $error("start bit");
    chk_full_scale: assert property ($rose(conversion_done_flag_q) && $past(over_range)
        && $past(active_channel_q[5:3]) == 3'h0 |-> result_q == acrs_pkg::FULL_SCALE)
        else $error("full scale");
    chk_phase_one: assert property ($onehot0({converting_q, tracking_q, settling_q}))
        else $error("phases");
    chk_chan_locked: assert property (converting_q && $past(converting_q)
        |-> $stable(active_channel_q)) else $error("channel moved");
    chk_ref_stable: assert property (reference_stable_flag_q
        |-> reference_source_q[1] || reference_source_q[2]) else $error("ref ok");
    chk_settle_hold: assert property (settling_q |-> !sample_hold_q)
        else $error("settle");
    chk_off_idle: assert property (!converter_enable_bit |=> !conversion_start_bit_q)
        else $error("off");
endmodule : acrs_seq_checker
bind acrs_sequencer acrs_seq_checker i_chk (.clock, .reset_n, .converter_enable_bit,
    .free_running_select, .over_range, .clock_prescale_select, .conversion_start_bit_q,
    .conversion_done_flag_q, .result_q, .active_channel_q, .reference_source_q,
    .reference_stable_flag_q, .sample_hold_q, .converting_q, .tracking_q, .settling_q);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clock, reset_n, converter_enable_bit, auto_trigger_enable_bit, free_running_select;
    logic start_write, done_flag_clear, done_irq_enable, sleep_halted, channel_select_high_write;
    logic channel_select_high, channel_select_low_write, reference_select_write, trigger_pin;
    logic analog_supply_ok_pin, reference_ready_pin, over_range, hot;
    logic conversion_start_bit_q, conversion_done_flag_q, reference_stable_flag_q, sample_hold_q;
    logic converting_q, tracking_q, settling_q;
    logic [2:0] clock_prescale_select;
    logic [1:0] track_hold_time_setting, reference_select_bits;
    logic [4:0] startup_time_setting, channel_select_low;
    logic [9:0] core_result, result_q;
    logic [5:0] active_channel_q;
    logic [3:0] reference_source_q;
    int n_errors = 0, n_compared = 0, cycles = 0, sh_count = 0;
    acrs_sequencer i_dut (.*);
    acrs_analog_model i_ana (.clock, .reset_n, .channel(active_channel_q), .hot,
        .supply_ok(analog_supply_ok_pin), .ref_ready(reference_ready_pin), .over_range,
        .core_result);
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Hang guard and sample pulse count
    always @(posedge clock)
    begin
        cycles++;
        sh_count += (sample_hold_q === 1'b1);
        if (cycles == 3000)
        begin
            n_errors++;
            complete_run();
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One strobed write: 0 start, 1 low channel field, 2 reference, 3 clear done, 4 high bit
    task wr(input int k, input logic [4:0] v);
        @(posedge clock);
        channel_select_low <= v;
        channel_select_high <= v[0];
        channel_select_high_write <= (k == 4);
        reference_select_bits <= v[1:0];
        start_write <= (k == 0);
        channel_select_low_write <= (k == 1);
        reference_select_write <= (k == 2);
        done_flag_clear <= (k == 3);
        @(posedge clock);
        {start_write, channel_select_low_write, reference_select_write, done_flag_clear} <= 4'h0;
        channel_select_high_write <= 1'b0;
        #1;
    endtask : wr
    task wait_done;
        for (int i = 0; i < 300 && conversion_done_flag_q !== 1'b1; i++)
            @(posedge clock);
        #1;
    endtask : wait_done
    task complete_run;
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial
    begin
        {reset_n, converter_enable_bit, auto_trigger_enable_bit, free_running_select} = 4'h0;
        {start_write, done_flag_clear, done_irq_enable, sleep_halted, hot} = 5'h00;
        {channel_select_high_write, channel_select_high, channel_select_low_write} = 3'h0;
        {reference_select_write, trigger_pin} = 2'h0;
        clock_prescale_select = 3'h1;
        track_hold_time_setting = 2'h0;
        reference_select_bits = 2'h0;
        startup_time_setting = 5'h00;
        channel_select_low = 5'h01;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        converter_enable_bit <= 1'b1;
        repeat (20) @(posedge clock);
        for (int r = 0; r < 4; r++)
        begin
            wr(2, 5'(r));
            repeat (4) @(posedge clock);
            #1;
            chk(reference_source_q, 16'h1 << r);
            chk(reference_stable_flag_q, (r == 1 || r == 2));
        end
        hot <= 1'b1;
        wr(0, 5'h01);
        chk(conversion_start_bit_q, 16'h1);
        wait_done();
        chk({conversion_start_bit_q, result_q}, 16'h03ff);
        chk(sh_count, 16'h1);
        wr(1, 5'h02);
        repeat (3) @(posedge clock);
        #1;
        chk({active_channel_q, tracking_q, settling_q}, 16'h0009);
        hot <= 1'b0;
        wr(3, 5'h02);
        chk(conversion_done_flag_q, 16'h0);
        wr(0, 5'h02);
        wr(2, 5'h01);
        wait_done();
        chk({sh_count[1:0], result_q}, 16'h0902);
        chk(reference_source_q, 16'h8);
        wr(0, 5'h02);
        converter_enable_bit <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(conversion_start_bit_q, 16'h0);
        converter_enable_bit <= 1'b1;
        wr(2, 5'h01);
        repeat (4) @(posedge clock);
        #1;
        chk(reference_source_q, 16'h2);
        // Halted CPU starts a conversion
        wr(3, 5'h00);
        done_irq_enable <= 1'b1;
        sleep_halted <= 1'b1;
        wait_done();
        chk({conversion_done_flag_q, conversion_start_bit_q}, 16'h2);
        // Trigger edge in auto mode, held until tracking ends
        wr(3, 5'h00);
        auto_trigger_enable_bit <= 1'b1;
        trigger_pin <= 1'b1;
        wait_done();
        chk({conversion_done_flag_q, conversion_start_bit_q}, 16'h2);
        // High bit alone must not reach the active channel
        wr(4, 5'h01);
        wr(1, 5'h00);
        chk(active_channel_q, 16'h2);
        // Differential only after a fresh start-up; sample two ticks late
        converter_enable_bit <= 1'b0;
        repeat (2) @(posedge clock);
        converter_enable_bit <= 1'b1;
        hot <= 1'b1;
        wr(3, 5'h00);
        repeat (40) @(posedge clock);
        wr(0, 5'h00);
        repeat (4) @(posedge clock);
        #1;
        chk(sh_count, 16'h4);
        wait_done();
        chk({sh_count[3:0], result_q}, 16'h1520);
        // Free running: samples every 14 ticks
        free_running_select <= 1'b1;
        wr(0, 5'h00);
        repeat (100) @(posedge clock);
        #1;
        chk(sh_count, 16'h9);
        complete_run();
    end
endmodule : tb_top
